/* asm_pkg.sv */
// Constants, types and codes shared by the amplifier monitor-and-control logic.
// Assumes byte-wide serial streams already de-framed by the UARTs around it.
`default_nettype none
package asm_pkg;
  // ****************************************
  // Framing characters
  // ****************************************
  localparam logic [7:0] CH_LT    = 8'h3c;
  localparam logic [7:0] CH_GT    = 8'h3e;
  localparam logic [7:0] CH_A     = 8'h41;
  localparam logic [7:0] CH_HASH  = 8'h23;
  localparam logic [7:0] CH_L     = 8'h4c;
  localparam logic [7:0] CH_P     = 8'h50;
  localparam logic [7:0] CH_X     = 8'h58;
  localparam logic [7:0] CH_O     = 8'h4f;
  localparam logic [7:0] CH_S     = 8'h53;
  localparam logic [7:0] CH_T     = 8'h54;
  localparam logic [7:0] CH_F     = 8'h46;
  localparam logic [7:0] CH_R     = 8'h52;
  localparam logic [7:0] CH_ZERO  = 8'h30;
  localparam logic [7:0] CH_ONE   = 8'h31;
  localparam logic [7:0] CH_TWO   = 8'h32;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_CR    = 8'h0d;
  localparam logic [7:0] CH_LF    = 8'h0a;
  localparam logic [7:0] CH_LA    = 8'h61;
  // Terminal keys
  localparam logic [7:0] KEY_M    = 8'h6d;
  localparam logic [7:0] KEY_U    = 8'h75;
  localparam logic [7:0] KEY_N    = 8'h6e;
  localparam logic [7:0] KEY_SW1  = 8'h53;
  localparam logic [7:0] KEY_SW2  = 8'h57;
  // ****************************************
  // Checksum and lengths
  // ****************************************
  localparam logic [15:0] CK_BIAS = 16'h0020;
  localparam logic [15:0] CK_MOD  = 16'h005f;
  localparam logic [4:0]  LAST_L    = 5'h0a;
  localparam logic [4:0]  LAST_P    = 5'h18;
  localparam logic [4:0]  LAST_MENU = 5'h08;
  // ****************************************
  // Status byte fields
  // ****************************************
  localparam int ALM_SILENCED  = 7;
  localparam int ALM_LOCK_LOST = 5;
  localparam int RED_REDUNDANT = 0;
  localparam logic [7:0] ALM_CODE_OK = 8'h00;

  typedef struct packed {
    logic [7:0] alarm_flags;
    logic [7:0] redundancy_flags;
  } asm_stat_s;

  typedef enum logic [6:0] {
    RX_IDLE    = 7'b0000001,
    RX_ADDR_HI = 7'b0000010,
    RX_ADDR_LO = 7'b0000100,
    RX_FIXED_A = 7'b0001000,
    RX_CMD     = 7'b0010000,
    RX_BODY    = 7'b0100000,
    RX_FRAME_CHECKSUM    = 7'b1000000
  } asm_rx_e;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_LOAD = 3'b010,
    TX_WAIT = 3'b100
  } asm_tx_e;

  typedef enum logic [2:0] {
    KIND_L    = 3'b001,
    KIND_P    = 3'b010,
    KIND_MENU = 3'b100
  } asm_kind_e;
endpackage : asm_pkg
`default_nettype wire

/* asm_monitor_ctrl.sv */
// Serial monitor-and-control command interpreter of one amplifier unit.
// Assumes de-framed byte streams and status inputs on the CLK_SYS domain.
// What this block does
// - Alarm byte 0x20 lock lost, 0x80 silenced.
// - Enter key resends the main menu.
// - Terminal silence command disables RF output unless a bus restore completes in the same cycle.
// - Terminal restore command re-enables RF output unless a bus silence completes in the same cycle.
// - Path-toggle flips switch, redundant pair only; a bus set in the same cycle sets it instead.
// - Reply starts '>', address, A, data, '#', checksum.
// - Checksum: sum byte minus 0x20, mod 0x5f, plus 0x20.
// - Sixteen-bit sum through the '#' byte.
// - Indicator query answers L plus ASCII characters.
// - Alarm byte first, redundancy byte second.
// - Alarm byte bit map, bit 7 silenced.
// - Redundancy byte bit map, bits 7-5 unused.
// - Parameter query answers P plus labelled values.
// - Labels hotspot, shroud, forward, reflected power.
// - X then O sets switch on a redundant pair only, P restores, S silences.
// - Control commands get no reply.
`timescale 1ns/10ps
`default_nettype none
module asm_monitor_ctrl (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       NRST,
  // Unit address, 0 to 31
  input  wire logic [4:0] UNIT_ADDR,
  // Raw status from the unit
  input  wire logic [6:0] ALARM_IN,
  input  wire logic [7:0] REDUND_IN,
  input  wire logic [7:0] HOTSPOT_TEMP,
  input  wire logic [7:0] SHROUD_TEMP,
  input  wire logic [7:0] FWD_POWER,
  input  wire logic [7:0] REFL_POWER,
  // Terminal port
  input  wire logic       TERM_RX_VALID,
  input  wire logic [7:0] TERM_RX_DATA,
  output logic            TERM_TX_VALID,
  output logic [7:0]      TERM_TX_DATA,
  input  wire logic       TERM_TX_READY,
  // Multidrop port
  input  wire logic       BUS_RX_VALID,
  input  wire logic [7:0] BUS_RX_DATA,
  output logic            BUS_TX_VALID,
  output logic [7:0]      BUS_TX_DATA,
  input  wire logic       BUS_TX_READY,
  // Unit controls
  output logic            RF_ENABLE,
  output logic            GUIDE_SWITCH
);
  // ****************************************
  // Status bytes
  // ****************************************
  asm_pkg::asm_stat_s stat;
  // alarm bit map; bit 7 from silence state
  assign stat.alarm_flags      = {!RF_ENABLE, ALARM_IN};
  // bits 7 to 5 read zero
  assign stat.redundancy_flags = {3'h0, REDUND_IN[4:0]};
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? asm_pkg::CH_ZERO + {4'h0, n} : asm_pkg::CH_LA + {4'h0, n} - 8'h0a;
  endfunction : hex_char
  function automatic logic [7:0] dec_char(input logic [7:0] v, input logic [1:0] pos);
    logic [7:0] d;
    d = (pos == 2'h2) ? v / 8'd100 : (pos == 2'h1) ? (v / 8'd10) % 8'd10 : v % 8'd10;
    dec_char = asm_pkg::CH_ZERO + d;
  endfunction : dec_char
  // ****************************************
  // Terminal key decode
  // ****************************************
  logic [7:0] prev_key_ff;
  logic       term_enter, term_mute, term_unmute, term_toggle;
  assign term_enter  = TERM_RX_VALID && (TERM_RX_DATA == asm_pkg::CH_CR);
  assign term_mute   = TERM_RX_VALID && (prev_key_ff == asm_pkg::KEY_M) && (TERM_RX_DATA == asm_pkg::KEY_U);
  assign term_unmute = TERM_RX_VALID && (prev_key_ff == asm_pkg::KEY_U) && (TERM_RX_DATA == asm_pkg::KEY_N);
  assign term_toggle = TERM_RX_VALID && (prev_key_ff == asm_pkg::KEY_SW1) && (TERM_RX_DATA == asm_pkg::KEY_SW2)
                       && stat.redundancy_flags[asm_pkg::RED_REDUNDANT];
  // ****************************************
  // Request packet receiver
  // ****************************************
  asm_pkg::asm_rx_e rx_st_ff, nxt_rx_st;
  logic [15:0]      rx_sum_ff, rx_sum_add;
  logic [4:0]       rx_addr_ff;
  logic [7:0]       rx_cmd_ff, rx_sub_ff, rx_ck_want;
  logic             rx_sub_seen_ff, rx_ok;
  logic             do_query_l, do_query_p, do_set_guide, do_restore, do_silence;
  // bias each byte, 16-bit running sum
  assign rx_sum_add = rx_sum_ff + {8'h00, BUS_RX_DATA} - asm_pkg::CK_BIAS;
  assign rx_ck_want = 8'((rx_sum_ff % asm_pkg::CK_MOD) + asm_pkg::CK_BIAS);
  // drop bad checksum or other address
  assign rx_ok      = BUS_RX_VALID && (rx_st_ff == asm_pkg::RX_FRAME_CHECKSUM) && (BUS_RX_DATA == rx_ck_want)
                      && (rx_addr_ff == UNIT_ADDR);
  assign do_query_l   = rx_ok && (rx_cmd_ff == asm_pkg::CH_L);
  assign do_query_p   = rx_ok && (rx_cmd_ff == asm_pkg::CH_P);
  // X selects a control action; none of them answer
  assign do_set_guide = rx_ok && (rx_cmd_ff == asm_pkg::CH_X) && rx_sub_seen_ff && (rx_sub_ff == asm_pkg::CH_O)
                        && stat.redundancy_flags[asm_pkg::RED_REDUNDANT];
  assign do_restore   = rx_ok && (rx_cmd_ff == asm_pkg::CH_X) && rx_sub_seen_ff && (rx_sub_ff == asm_pkg::CH_P);
  assign do_silence   = rx_ok && (rx_cmd_ff == asm_pkg::CH_X) && rx_sub_seen_ff && (rx_sub_ff == asm_pkg::CH_S);
  always_comb begin
    nxt_rx_st = rx_st_ff;
    if (BUS_RX_VALID) begin
      if (BUS_RX_DATA == asm_pkg::CH_LT) begin
        nxt_rx_st = asm_pkg::RX_ADDR_HI;
      end else begin
        case (rx_st_ff)
          asm_pkg::RX_ADDR_HI: nxt_rx_st = asm_pkg::RX_ADDR_LO;
          asm_pkg::RX_ADDR_LO: nxt_rx_st = asm_pkg::RX_FIXED_A;
          asm_pkg::RX_FIXED_A: nxt_rx_st = (BUS_RX_DATA == asm_pkg::CH_A) ? asm_pkg::RX_CMD : asm_pkg::RX_IDLE;
          asm_pkg::RX_CMD:     nxt_rx_st = (BUS_RX_DATA == asm_pkg::CH_HASH) ? asm_pkg::RX_IDLE : asm_pkg::RX_BODY;
          asm_pkg::RX_BODY:    nxt_rx_st = (BUS_RX_DATA == asm_pkg::CH_HASH) ? asm_pkg::RX_FRAME_CHECKSUM : asm_pkg::RX_BODY;
          asm_pkg::RX_FRAME_CHECKSUM:    nxt_rx_st = asm_pkg::RX_IDLE;
          default:             nxt_rx_st = asm_pkg::RX_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      rx_st_ff       <= asm_pkg::RX_IDLE;
      rx_sum_ff      <= 16'h0000;
      rx_addr_ff     <= 5'h00;
      rx_cmd_ff      <= 8'h00;
      rx_sub_ff      <= 8'h00;
      rx_sub_seen_ff <= 1'b0;
    end else begin
      rx_st_ff <= nxt_rx_st;
      if (BUS_RX_VALID && (BUS_RX_DATA == asm_pkg::CH_LT)) begin
        rx_sum_ff      <= {8'h00, asm_pkg::CH_LT} - asm_pkg::CK_BIAS;
        rx_addr_ff     <= 5'h00;
        rx_sub_seen_ff <= 1'b0;
      end else if (BUS_RX_VALID && (rx_st_ff != asm_pkg::RX_FRAME_CHECKSUM) && (rx_st_ff != asm_pkg::RX_IDLE)) begin
        rx_sum_ff <= rx_sum_add;
        if (rx_st_ff == asm_pkg::RX_ADDR_HI) begin
          rx_addr_ff <= 5'({1'b0, BUS_RX_DATA[3:0]} * 5'd10);
        end
        if (rx_st_ff == asm_pkg::RX_ADDR_LO) begin
          rx_addr_ff <= rx_addr_ff + {1'b0, BUS_RX_DATA[3:0]};
        end
        if (rx_st_ff == asm_pkg::RX_CMD) begin
          rx_cmd_ff <= BUS_RX_DATA;
        end
        if ((rx_st_ff == asm_pkg::RX_BODY) && !rx_sub_seen_ff && (BUS_RX_DATA != asm_pkg::CH_HASH)) begin
          rx_sub_ff      <= BUS_RX_DATA;
          rx_sub_seen_ff <= 1'b1;
        end
      end
    end
  end
  // ****************************************
  // Unit control state
  // ****************************************
  // held until a command or reset
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      prev_key_ff  <= 8'h00;
      RF_ENABLE    <= 1'b1;
      GUIDE_SWITCH <= 1'b0;
    end else begin
      prev_key_ff <= TERM_RX_VALID ? TERM_RX_DATA : prev_key_ff;
      if (do_silence || (term_mute && !do_restore)) begin
        RF_ENABLE <= 1'b0;
      end else if (do_restore || term_unmute) begin
        RF_ENABLE <= 1'b1;
      end
      if (do_set_guide) begin
        GUIDE_SWITCH <= 1'b1;
      end else if (term_toggle) begin
        GUIDE_SWITCH <= !GUIDE_SWITCH;
      end
    end
  end
  // ****************************************
  // Reply and menu transmitter
  // ****************************************
  // One engine for both ports: a request that arrives while it is busy is dropped.
  asm_pkg::asm_tx_e   tx_st_ff;
  asm_pkg::asm_kind_e kind_ff;
  logic [4:0]         idx_ff, last_idx;
  logic [15:0]        tx_sum_ff;
  logic [7:0]         data_ff, cur_byte, tx_ck;
  logic               tx_ready;
  assign last_idx = (kind_ff == asm_pkg::KIND_P) ? asm_pkg::LAST_P :
                    (kind_ff == asm_pkg::KIND_L) ? asm_pkg::LAST_L : asm_pkg::LAST_MENU;
  assign tx_ready = (kind_ff == asm_pkg::KIND_MENU) ? TERM_TX_READY : BUS_TX_READY;
  assign tx_ck    = 8'((tx_sum_ff % asm_pkg::CK_MOD) + asm_pkg::CK_BIAS);
  always_comb begin
    cur_byte = asm_pkg::CH_SPACE;
    if (kind_ff == asm_pkg::KIND_MENU) begin
      case (idx_ff)
        5'h00, 5'h07: cur_byte = asm_pkg::CH_CR;
        5'h01, 5'h08: cur_byte = asm_pkg::CH_LF;
        5'h02:        cur_byte = hex_char(stat.alarm_flags[7:4]);
        5'h03:        cur_byte = hex_char(stat.alarm_flags[3:0]);
        5'h05:        cur_byte = hex_char(stat.redundancy_flags[7:4]);
        5'h06:        cur_byte = hex_char(stat.redundancy_flags[3:0]);
        default:      cur_byte = asm_pkg::CH_SPACE;
      endcase
    end else if (idx_ff == last_idx) begin
      cur_byte = tx_ck;
    end else if (idx_ff == last_idx - 5'h01) begin
      cur_byte = asm_pkg::CH_HASH;
    end else if (idx_ff < 5'h05) begin
      case (idx_ff)
        5'h00:   cur_byte = asm_pkg::CH_GT;
        5'h01:   cur_byte = dec_char({3'h0, UNIT_ADDR}, 2'h1);
        5'h02:   cur_byte = dec_char({3'h0, UNIT_ADDR}, 2'h0);
        5'h03:   cur_byte = asm_pkg::CH_A;
        default: cur_byte = (kind_ff == asm_pkg::KIND_L) ? asm_pkg::CH_L : asm_pkg::CH_P;
      endcase
    end else if (kind_ff == asm_pkg::KIND_L) begin
      // alarm then redundancy, as ASCII hex
      case (idx_ff)
        5'h05:   cur_byte = hex_char(stat.alarm_flags[7:4]);
        5'h06:   cur_byte = hex_char(stat.alarm_flags[3:0]);
        5'h07:   cur_byte = hex_char(stat.redundancy_flags[7:4]);
        default: cur_byte = hex_char(stat.redundancy_flags[3:0]);
      endcase
    end else begin
      case (idx_ff)
        5'h05, 5'h0a: cur_byte = asm_pkg::CH_T;
        5'h06:        cur_byte = asm_pkg::CH_ONE;
        5'h07:        cur_byte = dec_char(HOTSPOT_TEMP, 2'h2);
        5'h08:        cur_byte = dec_char(HOTSPOT_TEMP, 2'h1);
        5'h09:        cur_byte = dec_char(HOTSPOT_TEMP, 2'h0);
        5'h0b:        cur_byte = asm_pkg::CH_TWO;
        5'h0c:        cur_byte = dec_char(SHROUD_TEMP, 2'h2);
        5'h0d:        cur_byte = dec_char(SHROUD_TEMP, 2'h1);
        5'h0e:        cur_byte = dec_char(SHROUD_TEMP, 2'h0);
        5'h0f:        cur_byte = asm_pkg::CH_F;
        5'h10:        cur_byte = dec_char(FWD_POWER, 2'h2);
        5'h11:        cur_byte = dec_char(FWD_POWER, 2'h1);
        5'h12:        cur_byte = dec_char(FWD_POWER, 2'h0);
        5'h13:        cur_byte = asm_pkg::CH_R;
        5'h14:        cur_byte = dec_char(REFL_POWER, 2'h2);
        5'h15:        cur_byte = dec_char(REFL_POWER, 2'h1);
        default:      cur_byte = dec_char(REFL_POWER, 2'h0);
      endcase
    end
  end
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      tx_st_ff      <= asm_pkg::TX_IDLE;
      kind_ff       <= asm_pkg::KIND_MENU;
      idx_ff        <= 5'h00;
      tx_sum_ff     <= 16'h0000;
      data_ff       <= 8'h00;
      TERM_TX_VALID <= 1'b0;
      BUS_TX_VALID  <= 1'b0;
    end else begin
      case (tx_st_ff)
        asm_pkg::TX_IDLE: begin
          idx_ff    <= 5'h00;
          tx_sum_ff <= 16'h0000;
          if (do_query_l || do_query_p || term_enter) begin
            kind_ff  <= do_query_l ? asm_pkg::KIND_L : do_query_p ? asm_pkg::KIND_P : asm_pkg::KIND_MENU;
            tx_st_ff <= asm_pkg::TX_LOAD;
          end
        end
        asm_pkg::TX_LOAD: begin
          data_ff       <= cur_byte;
          tx_sum_ff     <= tx_sum_ff + {8'h00, cur_byte} - asm_pkg::CK_BIAS;
          TERM_TX_VALID <= (kind_ff == asm_pkg::KIND_MENU);
          BUS_TX_VALID  <= (kind_ff != asm_pkg::KIND_MENU);
          tx_st_ff      <= asm_pkg::TX_WAIT;
        end
        asm_pkg::TX_WAIT: begin
          if (tx_ready) begin
            TERM_TX_VALID <= 1'b0;
            BUS_TX_VALID  <= 1'b0;
            idx_ff        <= idx_ff + 5'h01;
            tx_st_ff      <= (idx_ff == last_idx) ? asm_pkg::TX_IDLE : asm_pkg::TX_LOAD;
          end
        end
        default: tx_st_ff <= asm_pkg::TX_IDLE;
      endcase
    end
  end
  assign TERM_TX_DATA = data_ff;
  assign BUS_TX_DATA  = data_ff;
endmodule : asm_monitor_ctrl
`default_nettype wire

/* asm_ctrl_chk.sv */
// Port checker for the amplifier monitor-and-control block.
// Assumes one clock domain; bound onto every asm_monitor_ctrl.
`timescale 1ns/10ps
`default_nettype none
module asm_ctrl_chk (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       NRST,
  // Watched ports
  input wire logic [7:0] REDUND_IN,
  input wire logic       TERM_RX_VALID,
  input wire logic [7:0] TERM_RX_DATA,
  input wire logic       TERM_TX_VALID,
  input wire logic [7:0] TERM_TX_DATA,
  input wire logic       BUS_RX_VALID,
  input wire logic       BUS_TX_VALID,
  input wire logic [7:0] BUS_TX_DATA,
  input wire logic       BUS_TX_READY,
  input wire logic       RF_ENABLE,
  input wire logic       GUIDE_SWITCH
);
  // ****
  // Key pairs and transmitter quiet time
  // ****
  logic [7:0] prev_ff;
  logic [1:0] idle_ff;
  wire        key_mu = TERM_RX_VALID && prev_ff == 8'h6d && TERM_RX_DATA == 8'h75 && !BUS_RX_VALID;
  wire        key_un = TERM_RX_VALID && prev_ff == 8'h75 && TERM_RX_DATA == 8'h6e && !BUS_RX_VALID;
  wire        key_sw = TERM_RX_VALID && prev_ff == 8'h53 && TERM_RX_DATA == 8'h57 && !BUS_RX_VALID;
  // A menu request is only judged once both transmitters sat idle, since busy drops it
  wire        quiet  = idle_ff == 2'h3;
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      prev_ff <= 8'h00;
      idle_ff <= 2'h0;
    end else begin
      if (TERM_RX_VALID)
        prev_ff <= TERM_RX_DATA;
      if (TERM_TX_VALID || BUS_TX_VALID)
        idle_ff <= 2'h0;
      else if (!quiet)
        idle_ff <= idle_ff + 2'h1;
    end
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // ****
  // Assertions
  // ****
  a_bus_tx_hold: assert property (BUS_TX_VALID && !BUS_TX_READY |=> BUS_TX_VALID && $stable(BUS_TX_DATA))
    else $error("multidrop byte changed before acceptance");
  a_bus_tx_gap: assert property (BUS_TX_VALID && BUS_TX_READY |=> !BUS_TX_VALID)
    else $error("multidrop valid held after acceptance");
  a_term_mute: assert property (key_mu |=> !RF_ENABLE)
    else $error("silence keys left RF on");
  a_term_restore: assert property (key_un |=> RF_ENABLE)
    else $error("restore keys left RF off");
  a_switch_alone: assert property (key_sw && !REDUND_IN[0] |=> $stable(GUIDE_SWITCH))
    else $error("standalone unit moved its switch");
  a_switch_flip: assert property (key_sw && REDUND_IN[0] |=> GUIDE_SWITCH != $past(GUIDE_SWITCH))
    else $error("redundant unit kept its switch");
  a_rf_retained: assert property ($changed(RF_ENABLE) |-> $past(TERM_RX_VALID) || $past(BUS_RX_VALID))
    else $error("RF enable changed with no command");
  a_guide_retained: assert property ($changed(GUIDE_SWITCH) |-> $past(TERM_RX_VALID || BUS_RX_VALID))
    else $error("switch changed with no command");
  a_menu_start: assert property (TERM_RX_VALID && TERM_RX_DATA == 8'h0d && quiet |-> ##2 TERM_TX_VALID && TERM_TX_DATA == 8'h0d)
    else $error("menu did not start with carriage return");
  c_silenced: cover property ($fell(RF_ENABLE));
  c_online: cover property ($rose(GUIDE_SWITCH));
  c_reply: cover property (BUS_TX_VALID && BUS_TX_READY);
endmodule : asm_ctrl_chk
bind asm_monitor_ctrl asm_ctrl_chk i_chk (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .REDUND_IN(REDUND_IN), .TERM_RX_VALID(TERM_RX_VALID),
  .TERM_RX_DATA(TERM_RX_DATA), .TERM_TX_VALID(TERM_TX_VALID), .TERM_TX_DATA(TERM_TX_DATA),
  .BUS_RX_VALID(BUS_RX_VALID), .BUS_TX_VALID(BUS_TX_VALID), .BUS_TX_DATA(BUS_TX_DATA),
  .BUS_TX_READY(BUS_TX_READY), .RF_ENABLE(RF_ENABLE), .GUIDE_SWITCH(GUIDE_SWITCH)
);
`default_nettype wire

/* asm_host_model.sv */
// Host computer model: types terminal keys, sends framed requests, sinks replies.
// Assumes inputs change 1 ns after the rising edge of CLK_SYS.
`timescale 1ns/10ps
`default_nettype none
module asm_host_model (
  // Clock
  input wire logic       CLK_SYS,
  // Terminal port
  output logic           TERM_RX_VALID,
  output logic [7:0]     TERM_RX_DATA,
  input wire logic       TERM_TX_VALID,
  input wire logic [7:0] TERM_TX_DATA,
  output logic           TERM_TX_READY,
  // Multidrop port
  output logic           BUS_RX_VALID,
  output logic [7:0]     BUS_RX_DATA,
  input wire logic       BUS_TX_VALID,
  input wire logic [7:0] BUS_TX_DATA,
  output logic           BUS_TX_READY
);
  logic [7:0] bus_q[$];
  logic [7:0] term_q[$];
  logic       slow = 1'b0;
  int         cnt  = 0;
  initial begin
    {TERM_RX_VALID, TERM_RX_DATA, TERM_TX_READY} = {1'b0, 8'h00, 1'b1};
    {BUS_RX_VALID, BUS_RX_DATA, BUS_TX_READY} = {1'b0, 8'h00, 1'b1};
  end
  // ****
  // Receivers; a slow host takes one byte in three cycles
  // ****
  always @(posedge CLK_SYS) begin
    if (BUS_TX_VALID === 1'b1 && BUS_TX_READY)
      bus_q.push_back(BUS_TX_DATA);
    if (TERM_TX_VALID === 1'b1 && TERM_TX_READY)
      term_q.push_back(TERM_TX_DATA);
    #1;
    cnt = cnt + 1;
    BUS_TX_READY = !slow || (cnt % 3 == 0);
    TERM_TX_READY = !slow || (cnt % 3 == 1);
  end
  function automatic logic [7:0] frame_checksum(input string s);
    logic [15:0] acc;
    acc = 16'h0000;
    for (int i = 0; i < s.len(); i++)
      acc = acc + {8'h00, s[i]} - 16'h0020;
    return 8'((acc % 16'h005f) + 16'h0020);
  endfunction : frame_checksum
  // One byte per cycle; a released line shows the inverse of its last byte
  task automatic put(input logic bus, input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(posedge CLK_SYS);
      #1;
      if (bus)
        {BUS_RX_VALID, BUS_RX_DATA} = {1'b1, s[i]};
      else
        {TERM_RX_VALID, TERM_RX_DATA} = {1'b1, s[i]};
    end
    @(posedge CLK_SYS);
    #1;
    if (bus)
      {BUS_RX_VALID, BUS_RX_DATA} = {1'b0, ~BUS_RX_DATA};
    else
      {TERM_RX_VALID, TERM_RX_DATA} = {1'b0, ~TERM_RX_DATA};
  endtask : put
  // start mark, address, fixed letter, end mark, checksum
  task automatic send_pkt(input string body, input logic bad);
    string s;
    s = {"<", body, "#"};
    s = {s, "?"};
    s[s.len() - 1] = frame_checksum(s.substr(0, s.len() - 2)) + {7'h00, bad};
    put(1'b1, s);
  endtask : send_pkt
endmodule : asm_host_model
`default_nettype wire

/* asm_monitor_ctrl_tb_top.sv */
// Self-checking bench: host model on both ports, status inputs from here.
// Assumes the checker and host model files are compiled before this one.
`timescale 1ns/10ps
`default_nettype none
module asm_monitor_ctrl_tb_top;
  logic       clk_sys = 1'b0;
  logic       nrst = 1'b0;
  logic [4:0] unit_addr = 5'h07;
  logic [6:0] alarm_in = 7'h20;
  logic [7:0] redund_in = 8'hfa;
  logic       trv, ttv, ttr, brv, btv, btr, rf_enable, guide_switch;
  logic [7:0] trd, ttd, brd, btd;
  int         err_total = 0;
  int         check_count = 0;
  always #10 clk_sys = ~clk_sys;
  asm_monitor_ctrl i_dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .UNIT_ADDR(unit_addr), .ALARM_IN(alarm_in), .REDUND_IN(redund_in),
    .HOTSPOT_TEMP(8'h25), .SHROUD_TEMP(8'hc8), .FWD_POWER(8'h05), .REFL_POWER(8'h00),
    .TERM_RX_VALID(trv), .TERM_RX_DATA(trd), .TERM_TX_VALID(ttv), .TERM_TX_DATA(ttd), .TERM_TX_READY(ttr),
    .BUS_RX_VALID(brv), .BUS_RX_DATA(brd), .BUS_TX_VALID(btv), .BUS_TX_DATA(btd), .BUS_TX_READY(btr),
    .RF_ENABLE(rf_enable), .GUIDE_SWITCH(guide_switch)
  );
  asm_host_model i_host (
    .CLK_SYS(clk_sys), .TERM_RX_VALID(trv), .TERM_RX_DATA(trd), .TERM_TX_VALID(ttv), .TERM_TX_DATA(ttd),
    .TERM_TX_READY(ttr), .BUS_RX_VALID(brv), .BUS_RX_DATA(brd), .BUS_TX_VALID(btv), .BUS_TX_DATA(btd),
    .BUS_TX_READY(btr)
  );
  // ****
  // Checking tasks
  // ****
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic state(input logic rf, input logic sw);
    repeat (4) @(posedge clk_sys);
    #2;
    chk("rf enable", {7'h00, rf}, {7'h00, rf_enable});
    chk("guide switch", {7'h00, sw}, {7'h00, guide_switch});
  endtask : state
  // Bus replies get their checksum appended; waits bounded, then looks for extras
  task automatic take(input logic bus, input string exp);
    int         n;
    logic [7:0] ck;
    logic [7:0] q[$];
    ck = i_host.frame_checksum(exp);
    if (bus)
      exp = {exp, "?"};
    if (bus)
      exp[exp.len() - 1] = ck;
    n = 0;
    while (n < 600 && (bus ? i_host.bus_q.size() : i_host.term_q.size()) < exp.len()) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (12) @(posedge clk_sys);
    #1;
    if (bus)
      q = i_host.bus_q;
    else
      q = i_host.term_q;
    chk("reply length", 8'(exp.len()), 8'(q.size()));
    for (int i = 0; i < exp.len(); i++)
      chk("reply byte", exp[i], q[i]);
    i_host.bus_q.delete();
    i_host.term_q.delete();
  endtask : take
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    give_verdict();
  end
  // ****
  // Test sequence
  // ****
  initial begin
    repeat (4) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    state(1'b1, 1'b0);
    chk("bus valid", 8'h00, {7'h00, btv});
    i_host.send_pkt("07AL", 1'b0);
    take(1'b1, ">07AL201a#");
    i_host.slow = 1'b1;
    i_host.put(1'b0, "mu");
    state(1'b0, 1'b0);
    i_host.send_pkt("07AL", 1'b0);
    take(1'b1, ">07ALa01a#");
    alarm_in = 7'h00;
    i_host.send_pkt("07AL", 1'b0);
    take(1'b1, ">07AL801a#");
    i_host.put(1'b0, "un");
    state(1'b1, 1'b0);
    i_host.put(1'b0, "SW");
    state(1'b1, 1'b0);
    redund_in = 8'h01;
    i_host.put(1'b0, "SW");
    state(1'b1, 1'b1);
    i_host.put(1'b0, "SW");
    state(1'b1, 1'b0);
    i_host.send_pkt("07AXS", 1'b0);
    i_host.send_pkt("07AXO1", 1'b0);
    state(1'b0, 1'b1);
    i_host.send_pkt("07AXP", 1'b0);
    state(1'b1, 1'b1);
    i_host.send_pkt("07AL", 1'b0);
    take(1'b1, ">07AL0001#");
    i_host.send_pkt("07AXS", 1'b1);
    i_host.send_pkt("08AXS", 1'b0);
    state(1'b1, 1'b1);
    i_host.put(1'b1, "<07AX");
    i_host.send_pkt("07AXS", 1'b0);
    state(1'b0, 1'b1);
    chk("silent replies", 8'h00, 8'(i_host.bus_q.size()));
    i_host.send_pkt("07AP", 1'b0);
    take(1'b1, ">07APT1037T2200F005R000#");
    unit_addr = 5'h10;
    i_host.send_pkt("16AL", 1'b0);
    take(1'b1, ">16AL8001#");
    i_host.put(1'b0, "\015");
    take(1'b0, "\015\01280 01\015\012");
    @(posedge clk_sys);
    #1;
    nrst = 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    state(1'b1, 1'b0);
    give_verdict();
  end
endmodule : asm_monitor_ctrl_tb_top
`default_nettype wire
